// ==== rss_pkg.sv ====
// constants and types for the radio sequence selector
// assumes a single ref_clk domain and a synchronous register write port
package rss_pkg;
  // register offset and field positions
  localparam logic [7:0] CTRL_OFFSET    = 8'h03;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam int         TIMER_TRIG_BIT = 7;
  localparam int         SLOTTED_BIT    = 6;
  localparam int         CCA_TX_BIT     = 5;
  localparam int         ACK_REQ_BIT    = 4;
  localparam int         AUTO_ACK_BIT   = 3;
  localparam int         SEQ_LSB        = 0;

  // selector encodings
  localparam logic [2:0] SEQ_IDLE = 3'h0;
  localparam logic [2:0] SEQ_RX   = 3'h1;
  localparam logic [2:0] SEQ_TX   = 3'h2;
  localparam logic [2:0] SEQ_CCA  = 3'h3;
  localparam logic [2:0] SEQ_TR   = 3'h4;
  localparam logic [2:0] SEQ_CONTINUOUS_CHANNEL_ASSESSMENT_SEQUENCE = 3'h5;

  // one-hot sequence states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ARMED = 4'h2,
    ST_RUN   = 4'h4,
    ST_ACK   = 4'h8
  } rss_state_t;

  // register write request
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } rss_wr_t;

  // radio event inputs from the datapath
  typedef struct packed {
    logic timerMatch;
    logic rxFrameDone;
    logic rxIsAck;
    logic txDone;
    logic ccaDone;
    logic ackTxDone;
    logic ackAllowed;
  } rss_evt_t;

  // sequence one-hot run indication
  typedef struct packed {
    logic rx;
    logic tx;
    logic cca;
    logic tr;
    logic continuous_channel_assessment_sequence;
  } rss_run_t;
endpackage

// ==== rss_radio_model.sv ====
// radio datapath stand-in: completion pulses for tx, cca and ack
// assumes run levels from the selector and frame requests from the bench
`timescale 1ns/1ns
module rss_radio_model (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire rss_pkg::rss_run_t seqRun,
  input  wire logic              ackTxStart,
  input  wire logic [2:0]        frame,   // go, is ack, ack allowed
  input  wire logic              tmMatch,
  output rss_pkg::rss_evt_t      radioEvt
);
  logic       act_q;  // tx or cca phase seen last cycle
  logic [2:0] done_q; // delay to tx or cca completion
  logic [1:0] ack_q;  // delay to ack sent
  wire logic  act = seqRun.tx | seqRun.tr | seqRun.cca;
  // finish each tx, tr, cca or ack phase a few cycles after it starts; rx and continuous assessment get no completion here
  always_ff @(posedge ref_clk) begin
    act_q  <= act & !sys_rst;
    done_q <= sys_rst ? 3'h0 : {done_q[1:0], act & !act_q};
    ack_q  <= sys_rst ? 2'h0 : {ack_q[0], ackTxStart};
  end
  assign radioEvt = '{tmMatch, frame[2], frame[1], done_q[2], done_q[2], ack_q[1], frame[0]};
endmodule

// ==== rss_sequence_selector.sv ====
// radio sequence selector: control register and autosequence control
// assumes the register port and radio events are synchronous to ref_clk
`timescale 1ns/1ns
module rss_sequence_selector (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire rss_pkg::rss_wr_t  regWr,
  input  wire rss_pkg::rss_evt_t radioEvt,
  output logic [7:0]             regRdData,
  output rss_pkg::rss_run_t      seqRun,
  output logic                   seqBusy,
  output logic                   ackTxStart,
  output logic                   frameAccept,
  output logic                   frameReject,
  output logic                   seqDone
);
  // control register and state
  // the control byte is the only register here; it holds the timer trigger,
  // the two acknowledge controls and the sequence code in its low three bits
  // st_q tracks the running autosequence; active_q remembers which code started it
  // so that later writes of bits 2:0 cannot retarget a sequence in flight
  // all outputs below come from flops so the host side sees clean levels
  // pulses last exactly one cycle and never fire on an abort
  logic [7:0]          ctrl_q;        // stored control byte
  logic [7:0]          ctrl_d;        // next control byte
  rss_pkg::rss_state_t st_q;          // sequence state
  rss_pkg::rss_state_t st_d;          // next state
  logic [2:0]          active_q;      // latched running code
  logic                ackTx_q;       // ack start pulse
  logic                acc_q;         // frame accepted pulse
  logic                rej_q;         // frame rejected pulse
  logic                done_q;        // sequence done pulse
  rss_pkg::rss_run_t   run_q;         // run indication
  logic                trTx_q;        // transmit half of tr finished

  // field views
  // a write only counts when strobed at the control offset
  // wrSeq is the code carried by this write, not the stored one
  // running follows the state, so it already covers the timer wait
  // the ack control bits are read from the stored byte, the timer bit of a start from the write data
  wire        ctrlHit  = regWr.en && (regWr.addr == rss_pkg::CTRL_OFFSET);
  wire [2:0]  wrSeq    = regWr.data[rss_pkg::SEQ_LSB +: 3];
  wire        wrIdle   = ctrlHit && (wrSeq == rss_pkg::SEQ_IDLE);
  wire        running  = (st_q != rss_pkg::ST_IDLE);
  wire        timerEn  = ctrl_q[rss_pkg::TIMER_TRIG_BIT];
  wire        ackReq   = ctrl_q[rss_pkg::ACK_REQ_BIT];
  wire        auto_ack_enable  = ctrl_q[rss_pkg::AUTO_ACK_BIT];

  // valid code check: reserved codes start nothing
  // idle is not a start either; it is handled as an abort
  // shared by the start decode and the control byte update
  function automatic logic seqValid(input logic [2:0] code);
    seqValid = (code != rss_pkg::SEQ_IDLE) && (code <= rss_pkg::SEQ_CONTINUOUS_CHANNEL_ASSESSMENT_SEQUENCE);
  endfunction

  wire        wrStart  = ctrlHit && !running && seqValid(wrSeq);
  // ack-required honoured only in transmit-then-receive
  wire        ackReqEff = ackReq && (active_q == rss_pkg::SEQ_TR);
  // auto-ack only in receive and transmit-then-receive
  wire        autoAckEff = auto_ack_enable && ((active_q == rss_pkg::SEQ_RX) || (active_q == rss_pkg::SEQ_TR));
  // receive phase: plain receive at once, tr only after its own frame went out
  // a frame end seen during the transmit half of tr is not a reply
  // and must neither be accepted nor rejected
  // the flag is cleared on every start and on every return to idle
  wire        rxSeq    = (active_q == rss_pkg::SEQ_RX) ||
                         ((active_q == rss_pkg::SEQ_TR) && trTx_q);
  wire        rxEnd    = (st_q == rss_pkg::ST_RUN) && rxSeq && radioEvt.rxFrameDone;
  // with ack-required, only acknowledge frames pass
  wire        rxOk     = rxEnd && (!ackReqEff || radioEvt.rxIsAck);
  wire        rxBad    = rxEnd && ackReqEff && !radioEvt.rxIsAck;
  wire        sendAck  = rxOk && autoAckEff && radioEvt.ackAllowed && !radioEvt.rxIsAck;
  wire        otherEnd = (st_q == rss_pkg::ST_RUN) &&
                         (((active_q == rss_pkg::SEQ_TX) && radioEvt.txDone) ||
                          ((active_q == rss_pkg::SEQ_CCA) && radioEvt.ccaDone));
  wire        finish   = (rxOk && !sendAck) || otherEnd ||
                         ((st_q == rss_pkg::ST_ACK) && radioEvt.ackTxDone);

  // control byte: non-idle writes while running keep the old code
  // the upper control bits are always taken, even mid-sequence,
  // so the host can change ack handling for the next run
  // a reserved code is stored as idle so a read back shows nothing runs
  // an idle write always lands and so doubles as the abort
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrlHit) begin
      if (running && !wrIdle) begin
        ctrl_d = {regWr.data[7:3], ctrl_q[2:0]};
      end else if (!seqValid(wrSeq)) begin
        ctrl_d = {regWr.data[7:3], rss_pkg::SEQ_IDLE};
      end else begin
        ctrl_d = regWr.data;
      end
    end
  end

  // next state
  // idle waits for a valid start write; armed waits on the timer match
  // run ends on the completion event of its sequence
  // ack covers the hardware acknowledge transmit after a receive
  // continuous assessment only leaves run by an idle write
  // the abort check comes last so it overrides every other transition
  // a reject keeps the sequence in run, still listening for a reply
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      rss_pkg::ST_IDLE: begin
        // immediate or timer-scheduled start
        if (wrStart) begin
          st_d = regWr.data[rss_pkg::TIMER_TRIG_BIT] ? rss_pkg::ST_ARMED : rss_pkg::ST_RUN;
        end
      end
      rss_pkg::ST_ARMED: begin
        if (radioEvt.timerMatch) begin
          st_d = rss_pkg::ST_RUN;
        end
      end
      rss_pkg::ST_RUN: begin
        if (sendAck) begin
          st_d = rss_pkg::ST_ACK;
        end else if (finish) begin
          st_d = rss_pkg::ST_IDLE;
        end
      end
      rss_pkg::ST_ACK: begin
        if (radioEvt.ackTxDone) begin
          st_d = rss_pkg::ST_IDLE;
        end
      end
      default: st_d = rss_pkg::ST_IDLE;
    endcase
    // idle write aborts anything in progress
    if (wrIdle) begin
      st_d = rss_pkg::ST_IDLE;
    end
  end

  // register and state update
  // active_q is loaded from the write itself on a start
  // and returns to idle whenever the state does
  // trTx_q opens the receive half of transmit-then-receive
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q   <= rss_pkg::CTRL_RESET;
      st_q     <= rss_pkg::ST_IDLE;
      active_q <= rss_pkg::SEQ_IDLE;
      trTx_q   <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      st_q   <= st_d;
      if (wrStart) begin
        active_q <= wrSeq;
      end else if (st_d == rss_pkg::ST_IDLE) begin
        active_q <= rss_pkg::SEQ_IDLE;
      end
      // tr receive half opens once its frame has gone out
      if (wrStart || (st_d == rss_pkg::ST_IDLE)) begin
        trTx_q <= 1'b0;
      end else if ((st_q == rss_pkg::ST_RUN) && (active_q == rss_pkg::SEQ_TR) && radioEvt.txDone) begin
        trTx_q <= 1'b1;
      end
    end
  end

  // registered outputs
  // every pulse is masked by an idle write in the same cycle,
  // so an abort never reports a frame or a completion
  // the run levels look at the next state, so they rise with busy
  // on a start the code comes from the write, later from active_q
  // receive levels stay up through the acknowledge transmit
  // an armed sequence shows busy but no run level yet
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ackTx_q <= 1'b0;
      acc_q   <= 1'b0;
      rej_q   <= 1'b0;
      done_q  <= 1'b0;
      run_q   <= '0;
    end else begin
      ackTx_q <= sendAck && !wrIdle;
      acc_q   <= rxOk && !wrIdle;
      rej_q   <= rxBad && !wrIdle;
      done_q  <= finish && !wrIdle;
      run_q.rx   <= (st_d == rss_pkg::ST_RUN || st_d == rss_pkg::ST_ACK) && (wrStart ? wrSeq : active_q) == rss_pkg::SEQ_RX;
      run_q.tx   <= (st_d == rss_pkg::ST_RUN) && (wrStart ? wrSeq : active_q) == rss_pkg::SEQ_TX;
      run_q.cca  <= (st_d == rss_pkg::ST_RUN) && (wrStart ? wrSeq : active_q) == rss_pkg::SEQ_CCA;
      run_q.tr   <= (st_d == rss_pkg::ST_RUN || st_d == rss_pkg::ST_ACK) && (wrStart ? wrSeq : active_q) == rss_pkg::SEQ_TR;
      run_q.continuous_channel_assessment_sequence <= (st_d == rss_pkg::ST_RUN) && (wrStart ? wrSeq : active_q) == rss_pkg::SEQ_CONTINUOUS_CHANNEL_ASSESSMENT_SEQUENCE;
    end
  end

  // output drive
  // read data mirrors the next control byte so it is current
  // from the write edge itself, together with ctrl_q
  // busy covers the timer wait as well as the run itself
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regRdData <= rss_pkg::CTRL_RESET;
      seqBusy   <= 1'b0;
    end else begin
      regRdData <= ctrl_d;
      seqBusy   <= (st_d != rss_pkg::ST_IDLE);
    end
  end

  // port outputs straight from the flops above
  // no logic between flop and pin
  assign seqRun      = run_q;
  assign ackTxStart  = ackTx_q;
  assign frameAccept = acc_q;
  assign frameReject = rej_q;
  assign seqDone     = done_q;
endmodule

// ==== rss_sequence_selector_tb.sv ====
// self-checking bench for the sequence selector
// assumes the radio stand-in closes tx, cca and ack phases
`timescale 1ns/1ns
module rss_sequence_selector_tb;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  rss_pkg::rss_wr_t  regWr   = '0;
  logic [2:0]        frame   = 3'h0;
  logic              tmMatch = 1'b0;
  rss_pkg::rss_evt_t radioEvt;
  rss_pkg::rss_run_t seqRun;
  logic [7:0]        regRdData;
  logic              seqBusy, ackTxStart, frameAccept, frameReject, seqDone;
  int                num_errors = 0;
  int                checked    = 0;
  wire logic [9:0]   st = {ackTxStart, frameAccept, frameReject, seqDone, seqBusy, seqRun};
  always #10 ref_clk = ~ref_clk;
  rss_sequence_selector uut (.ref_clk, .sys_rst, .regWr, .radioEvt, .regRdData, .seqRun, .seqBusy,
    .ackTxStart, .frameAccept, .frameReject, .seqDone);
  rss_radio_model radio (.ref_clk, .sys_rst, .seqRun, .ackTxStart, .frame, .tmMatch, .radioEvt);
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one register write, sampled after it lands
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) regWr <= '{1'b1, a, d};
    @(posedge ref_clk) regWr <= '0;
    @(negedge ref_clk);
  endtask
  // one radio event pulse
  task automatic ev(input logic [2:0] f, input logic t);
    @(posedge ref_clk) {frame, tmMatch} <= {f, t};
    @(posedge ref_clk) {frame, tmMatch} <= 4'h0;
    @(negedge ref_clk);
  endtask
  // bounded wait for the sequence to finish
  task automatic idle_wait();
    int n;
    for (n = 0; n < 20 && seqBusy !== 1'b0; n++) @(negedge ref_clk);
    if (n == 20) begin
      num_errors++;
      end_sim();
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    chk("reset", 10'h000, {2'h0, regRdData} | st);
    wr(8'h03, 8'h11);
    chk("rx start", 10'h030, st);
    ev(3'h4, 1'b0);
    chk("rx end", 10'h140, st);
    wr(8'h03, 8'h00);
    wr(8'h03, 8'h09);
    ev(3'h5, 1'b0);
    chk("auto ack", 10'h320, st & 10'h3e0);
    idle_wait();
    wr(8'h03, 8'h00);
    $display("test receive done");
    wr(8'h03, 8'h14);
    wr(8'h03, 8'h12);
    chk("kept code", 10'h014, {2'h0, regRdData});
    repeat (4) @(negedge ref_clk);
    ev(3'h4, 1'b0);
    chk("tr reject", 10'h0a0, st & 10'h3e0);
    ev(3'h6, 1'b0);
    chk("tr ack", 10'h140, st & 10'h3e0);
    wr(8'h03, 8'h00);
    for (int c = 6; c < 8; c++) begin
      wr(8'h03, 8'(c));
      chk("reserved", 10'h000, {2'h0, regRdData} | st);
    end
    $display("test tr and reserved done");
    wr(8'h03, 8'h82);
    chk("timer wait", 10'h020, st);
    ev(3'h0, 1'b1);
    chk("timer start", 10'h028, st);
    idle_wait();
    wr(8'h03, 8'h00);
    wr(8'h03, 8'h03);
    chk("cca", 10'h024, st);
    idle_wait();
    wr(8'h03, 8'h00);
    wr(8'h03, 8'h05);
    wr(8'h04, 8'h00);
    chk("other addr", 10'h021, st);
    wr(8'h03, 8'h00);
    chk("abort", 10'h000, {2'h0, regRdData} | st);
    $display("test timer and cca done");
    end_sim();
  end
endmodule

// ==== rss_sva.sv ====
// assertions on the sequence selector ports
// assumes binding onto rss_sequence_selector
`timescale 1ns/1ns
module rss_sva (
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire rss_pkg::rss_wr_t  regWr,
  input wire rss_pkg::rss_evt_t radioEvt,
  input wire logic [7:0]        regRdData,
  input wire rss_pkg::rss_run_t seqRun,
  input wire logic              seqBusy,
  input wire logic              ackTxStart,
  input wire logic              frameAccept,
  input wire logic              frameReject,
  input wire logic              seqDone
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic       w = regWr.en && regWr.addr == 8'h03;                  // control write
  wire logic [2:0] c = regWr.data[2:0];                                 // written code
  wire logic       f = radioEvt.rxFrameDone && !radioEvt.rxIsAck && !w; // data frame end
  a_idle_abort: assert property (w && c == 3'h0 |=> !seqBusy && seqRun == '0) else $error("no abort");
  a_busy_keep: assert property (seqBusy && w && c != 3'h0 |=>
    regRdData[2:0] == $past(regRdData[2:0])) else $error("code changed while busy");
  a_start_dec: assert property (!seqBusy && w && !regWr.data[7] |=>
    seqRun == $past({c == 3'h1, c == 3'h2, c == 3'h3, c == 3'h4, c == 3'h5})) else $error("bad start");
  a_timer_wait: assert property (!seqBusy && w && regWr.data[7] && c inside {[3'h1:3'h5]} |=>
    seqBusy && seqRun == '0) else $error("timer start not held");
  a_rsvd_idle: assert property (!seqBusy && w && c > 3'h5 |=> !seqBusy && regRdData[2:0] == 3'h0) else $error("rsvd");
  a_noack_end: assert property (seqRun.rx && !regRdData[3] && f |=>
    seqDone && frameAccept && !ackTxStart && !seqBusy) else $error("rx end wrong");
  a_ack_send: assert property (seqRun.rx && regRdData[3] && radioEvt.ackAllowed && f |=>
    ackTxStart && seqBusy) else $error("no ack sent");
  a_ackreq_rej: assert property (seqRun.tr && regRdData[4] && f |=>
    frameReject && !frameAccept && seqBusy) else $error("no reject");
  a_ackreq_ign: assert property (seqRun.rx && regRdData[4] && !regRdData[3] && f |=> frameAccept) else $error("rej");
  a_ack_scope: assert property (seqRun.tx || seqRun.cca || seqRun.continuous_channel_assessment_sequence |=> !ackTxStart) else $error("ack");
  c_ack: cover property (ackTxStart);
  c_rej: cover property (frameReject);
  c_done: cover property (seqDone);
endmodule
bind rss_sequence_selector rss_sva u_sva (.ref_clk, .sys_rst, .regWr, .radioEvt, .regRdData, .seqRun,
  .seqBusy, .ackTxStart, .frameAccept, .frameReject, .seqDone);
